// *** tb/xmi_ext_mem_iface_tb.sv ***
/*
 * Self-checking bench for the external data-memory interface.
 * Assumes the off-chip memory model; the on-chip array lives here.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        testsRun++; \
        if ((got) !== (exp)) \
        begin \
            $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
            nMismatch++; \
        end \
    end
module xmi_ext_mem_iface_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cfgWrite = 1'b0;
    logic [7:0] cfgData = 8'h00;
    logic tmgWrite = 1'b0;
    logic [7:0] tmgData = 8'h00;
    logic [7:0] pg = 8'h00;
    logic [7:0] ptrA = 8'h00;
    logic [7:0] ptrB = 8'h00;
    logic [15:0] data_pointer = 16'h0000;
    logic [7:0] portHi = 8'h00;
    logic reqValid = 1'b0;
    xmi_pkg::xmi_req_t req = '0;
    logic done;
    logic [7:0] rdata;
    logic [7:0] cfgRb;
    logic [7:0] tmgRb;
    logic xramEn;
    logic xramWe;
    logic [11:0] xramAddr;
    logic [7:0] xramWdata;
    logic [7:0] xramRdata;
    logic busy;
    xmi_pkg::xmi_pins_t pins;
    logic [7:0] adIn;
    logic [7:0] dataIn;
    logic [15:0] lastAddr;
    logic lastHi;
    logic [7:0] xmem [0:4095];
    logic [11:0] xAddr;
    int stbCnt = 0;
    int aleRun = 0;
    int aleW = 0;
    int cyc = 0;
    int nMismatch = 0;
    int testsRun = 0;

    xmi_ext_mem_iface DUT (.clk, .arst_n, .cfgWrite, .cfgData, .tmgWrite,
        .tmgData, .xramPageSelect(pg), .indirectPointerA(ptrA),
        .indirectPointerB(ptrB), .dataPointer(data_pointer), .reqValid, .req,
        .busy, .done, .rdata, .extMemConfigReg(cfgRb),
        .extMemTimingReg(tmgRb), .xramEn, .xramWe, .xramAddr, .xramWdata,
        .xramRdata, .pins, .adIn, .dataIn);

    xmi_sram_model XP (.clk, .pins, .sharedBus(~cfgRb[4]), .portHi, .adIn,
        .dataIn, .lastAddr, .lastHiDrive(lastHi));

    always #12.5 clk = ~clk;

    // on-chip array reads through: the interface takes it in the enable cycle
    assign xramRdata = xmem[xramAddr];

    always @(posedge clk)
    begin
        cyc++;
        if (xramEn && xramWe)
        begin
            xmem[xramAddr] <= xramWdata;
        end
        if (xramEn)
        begin
            xAddr <= xramAddr;
        end
        if (pins.readStb || pins.writeStb || pins.latchStb ||
            pins.dataDrive || pins.addrHiDrive)
        begin
            stbCnt <= stbCnt + 1;
        end
        aleRun <= pins.latchStb ? aleRun + 1 : 0;
        if (!pins.latchStb && aleRun != 0)
        begin
            aleW <= aleRun;
        end
        if (cyc == 3000)
        begin
            nMismatch++;
            final_report;
        end
    end

    task automatic final_report;
        if (nMismatch == 0 && testsRun > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic set_cfg(input logic [7:0] c, input logic [7:0] t);
        cfgData = c;
        tmgData = t;
        cfgWrite = 1'b1;
        tmgWrite = 1'b1;
        @(negedge clk);
        cfgWrite = 1'b0;
        tmgWrite = 1'b0;
        @(negedge clk);
        `CHK("config", c & 8'h1f, cfgRb)
        `CHK("timing", t, tmgRb)
    endtask

    // one move; length counted from request cycle to done cycle
    task automatic go(input logic w, input logic wd16, input logic b,
        input logic [7:0] wd, input int expLen, input logic [15:0] expA,
        input logic expHi);
        int n;
        int s0;
        s0 = stbCnt;
        req = '{write: w, wide: wd16, usePtrB: b, wdata: wd};
        reqValid = 1'b1;
        @(negedge clk);
        reqValid = 1'b0;
        `CHK("busy", expLen != 2, busy)
        n = 1;
        while (done !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        `CHK("length", expLen, n + 1)
        if (expLen == 2)
        begin
            `CHK("xdata_space address", expA[11:0], xAddr)
            `CHK("quiet pins", s0, stbCnt)
        end
        else
        begin
            `CHK("ext address", expA, lastAddr)
            `CHK("upper drive", expHi, lastHi)
        end
    endtask

    task automatic rd(input logic wd16, input logic b, input int expLen,
        input logic [15:0] expA, input logic expHi, input logic [7:0] d);
        go(1'b0, wd16, b, 8'h00, expLen, expA, expHi);
        @(negedge clk);
        `CHK("read data", d, rdata)
    endtask

    initial
    begin
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        `CHK("config reset", 8'h03, cfgRb)
        `CHK("timing reset", 8'hff, tmgRb)
        pg = 8'h13;
        ptrA = 8'h45;
        ptrB = 8'h99;
        portHi = 8'h5a;
        go(1'b1, 1'b0, 1'b0, 8'hc3, 2, 16'h1345, 1'b0);
        data_pointer = 16'h3345;
        rd(1'b1, 1'b0, 2, 16'h3345, 1'b0, 8'hc3);
        set_cfg(8'hfc, 8'h00);
        go(1'b1, 1'b0, 1'b1, 8'h6e, 5, 16'h5a99, 1'b0);
        data_pointer = 16'h5a99;
        rd(1'b1, 1'b0, 5, 16'h5a99, 1'b1, 8'h6e);
        data_pointer = 16'h0010;
        go(1'b1, 1'b1, 1'b0, 8'h21, 5, 16'h0010, 1'b1);
        set_cfg(8'h18, 8'h4b);
        pg = 8'h12;
        ptrA = 8'h34;
        go(1'b1, 1'b0, 1'b0, 8'h77, 11, 16'h1234, 1'b1);
        pg = 8'h01;
        ptrA = 8'h10;
        go(1'b1, 1'b0, 1'b0, 8'h3c, 2, 16'h0110, 1'b0);
        data_pointer = 16'h1234;
        rd(1'b1, 1'b0, 11, 16'h1234, 1'b1, 8'h77);
        set_cfg(8'h05, 8'h00);
        pg = 8'h40;
        ptrA = 8'h22;
        portHi = 8'h66;
        go(1'b1, 1'b0, 1'b0, 8'ha5, 9, 16'h6622, 1'b0);
        `CHK("latch width", 2, aleW)
        rd(1'b0, 1'b0, 9, 16'h6622, 1'b0, 8'ha5);
        set_cfg(8'h04, 8'h00);
        data_pointer = 16'h01ff;
        go(1'b1, 1'b1, 1'b0, 8'h11, 2, 16'h01ff, 1'b0);
        data_pointer = 16'h0200;
        go(1'b1, 1'b1, 1'b0, 8'h5e, 7, 16'h0200, 1'b1);
        `CHK("latch width", 1, aleW)
        rd(1'b1, 1'b0, 7, 16'h0200, 1'b1, 8'h5e);
        final_report;
    end
endmodule
`default_nettype wire

// *** tb/xmi_sram_model.sv ***
/*
 * Off-chip parallel SRAM with a transparent low-address latch.
 * Assumes active-high strobes in the pin struct and a port latch
 * value for upper address lines that the interface leaves undriven.
 */
`timescale 1ns/1ps
`default_nettype none
module xmi_sram_model (
    input wire logic clk,
    input wire xmi_pkg::xmi_pins_t pins,
    input wire logic sharedBus,
    input wire logic [7:0] portHi,
    output logic [7:0] adIn,
    output logic [7:0] dataIn,
    output logic [15:0] lastAddr,
    output logic lastHiDrive
);
    logic [7:0] mem [0:65535];
    logic [7:0] latchQ;
    logic [7:0] idlePat = 8'h5a;
    logic [15:0] addr;

    // follows the shared pins while high, frozen once it falls
    always_latch
    begin
        if (pins.latchStb)
        begin
            latchQ <= pins.addrLo;
        end
    end

    assign addr = {pins.addrHiDrive ? pins.addrHi : portHi,
        sharedBus ? latchQ : pins.addrLo};
    // released lines show a pattern that moves every cycle
    assign adIn = (sharedBus && pins.readStb) ? mem[addr] : idlePat;
    assign dataIn = (!sharedBus && pins.readStb) ? mem[addr] : ~idlePat;

    always @(posedge clk)
    begin
        idlePat <= idlePat + 8'h35;
        if (pins.writeStb)
        begin
            mem[addr] <= sharedBus ? pins.addrLo : pins.dataOut;
        end
        if (pins.readStb || pins.writeStb)
        begin
            lastAddr <= addr;
            lastHiDrive <= pins.addrHiDrive;
        end
    end
endmodule
`default_nettype wire

// *** verilog/xmi_ext_mem_iface.sv ***
/*
 * External data-memory interface: steers external moves to on-chip
 * xdata space or to an off-chip memory over a multiplexed or separate
 * address/data bus with programmable setup, strobe, hold and latch widths.
 * Assumes a core that raises reqValid for one cycle per move and waits
 * for done; pin muxing and the on-chip RAM array live outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "xmi_params.svh"

module xmi_ext_mem_iface #(
    parameter int XDATA_SPACE_BYTES = `XMI_XDATA_SPACE_BYTES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cfgWrite,
    input wire logic [7:0] cfgData,
    input wire logic tmgWrite,
    input wire logic [7:0] tmgData,
    input wire logic [7:0] xramPageSelect,
    input wire logic [7:0] indirectPointerA,
    input wire logic [7:0] indirectPointerB,
    input wire logic [15:0] dataPointer,
    input wire logic reqValid,
    input wire xmi_pkg::xmi_req_t req,
    output logic busy,
    output logic done,
    output logic [7:0] rdata,
    output logic [7:0] extMemConfigReg,
    output logic [7:0] extMemTimingReg,
    output logic xramEn,
    output logic xramWe,
    output logic [11:0] xramAddr,
    output logic [7:0] xramWdata,
    input wire logic [7:0] xramRdata,
    output xmi_pkg::xmi_pins_t pins,
    input wire logic [7:0] adIn,
    input wire logic [7:0] dataIn
);

    xmi_pkg::xmi_state_t state_r;
    logic [7:0] cfg_r;
    logic [7:0] tmg_r;
    logic [3:0] cnt_r;
    logic [15:0] addr_r;
    logic hiDrive_r;
    logic write_r;
    logic [7:0] wdata_r;
    logic muxed_r;
    logic onchipPend_r;
    logic [15:0] effAddr;
    logic offChip;
    logic [1:0] mapMode;
    logic [7:0] ptrLo;

    function automatic logic [3:0] width4(input logic [1:0] code);
        width4 = {2'b00, code};
    endfunction

    // cycles from launch to tail: programmed widths plus fixed overhead
    function automatic logic [6:0] acc_cycles(input logic [7:0] t,
        input logic [1:0] ale, input logic mux);
        acc_cycles = 7'(t[`XMI_TMG_SETUP_HI:`XMI_TMG_SETUP_LO]) +
            7'(t[`XMI_TMG_STRB_HI:`XMI_TMG_STRB_LO]) +
            7'(t[`XMI_TMG_HOLD_HI:`XMI_TMG_HOLD_LO]) +
            7'(`XMI_FIXED_CYCLES);
        if (mux)
            acc_cycles = acc_cycles + 7'd2 * 7'(ale) + 7'd2;
    endfunction

    assign mapMode = cfg_r[`XMI_CFG_MODE_HI:`XMI_CFG_MODE_LO];
    assign ptrLo = req.usePtrB ? indirectPointerB : indirectPointerA;
    assign extMemConfigReg = {3'b000, cfg_r[4:0]};
    assign extMemTimingReg = tmg_r;

    // effective address and on/off-chip steering
    always_comb
    begin
        effAddr = req.wide ? dataPointer : {xramPageSelect, ptrLo};
        case (mapMode)
            2'b00: offChip = 1'b0;
            2'b01, 2'b10: offChip = (effAddr >= 16'(XDATA_SPACE_BYTES));
            2'b11: offChip = 1'b1;
            default: offChip = 1'b0;
        endcase
    end

    // configuration registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_r <= `XMI_CFG_RESET;
            tmg_r <= `XMI_TMG_RESET;
        end
        else
        begin
            if (cfgWrite)
                cfg_r <= {3'b000, cfgData[4:0]};
            if (tmgWrite)
                tmg_r <= tmgData;
        end
    end

    // on-chip access: one cycle, external pins untouched
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            onchipPend_r <= 1'b0;
            xramEn <= 1'b0;
            xramWe <= 1'b0;
            xramAddr <= 12'h000;
            xramWdata <= 8'h00;
        end
        else
        begin
            xramEn <= 1'b0;
            xramWe <= 1'b0;
            onchipPend_r <= 1'b0;
            if (reqValid && !busy && !offChip)
            begin
                xramEn <= 1'b1;
                xramWe <= req.write;
                xramAddr <= effAddr[11:0];
                xramWdata <= req.wdata;
                onchipPend_r <= 1'b1;
            end
        end
    end

    // off-chip sequencer
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= xmi_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            addr_r <= 16'h0000;
            hiDrive_r <= 1'b0;
            write_r <= 1'b0;
            wdata_r <= 8'h00;
            muxed_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                xmi_pkg::ST_IDLE:
                begin
                    if (reqValid && offChip)
                    begin
                        addr_r <= effAddr;
                        hiDrive_r <= req.wide ||
                            (mapMode == 2'b10);
                        write_r <= req.write;
                        wdata_r <= req.wdata;
                        muxed_r <= ~cfg_r[`XMI_CFG_MUX_BIT];
                        // address launch from idle, not one of the fixed overhead cycles
                        state_r <= xmi_pkg::ST_SETUP;
                        cnt_r <= {2'b00,
                            tmg_r[`XMI_TMG_SETUP_HI:`XMI_TMG_SETUP_LO]};
                        if (!cfg_r[`XMI_CFG_MUX_BIT])
                        begin
                            state_r <= xmi_pkg::ST_ALEH;
                            cnt_r <= width4(
                                cfg_r[`XMI_CFG_ALE_HI:`XMI_CFG_ALE_LO]);
                        end
                    end
                end
                xmi_pkg::ST_ALEH:
                begin
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h0)
                    begin
                        state_r <= xmi_pkg::ST_ALEL;
                        cnt_r <= width4(
                            cfg_r[`XMI_CFG_ALE_HI:`XMI_CFG_ALE_LO]);
                    end
                end
                xmi_pkg::ST_ALEL:
                begin
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h0)
                    begin
                        state_r <= xmi_pkg::ST_SETUP;
                        cnt_r <= {2'b00,
                            tmg_r[`XMI_TMG_SETUP_HI:`XMI_TMG_SETUP_LO]};
                    end
                end
                xmi_pkg::ST_SETUP:
                begin
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h0)
                    begin
                        state_r <= xmi_pkg::ST_STROBE;
                        cnt_r <= tmg_r[`XMI_TMG_STRB_HI:`XMI_TMG_STRB_LO];
                    end
                end
                xmi_pkg::ST_STROBE:
                begin
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h0)
                    begin
                        state_r <= xmi_pkg::ST_HOLD;
                        cnt_r <= {2'b00,
                            tmg_r[`XMI_TMG_HOLD_HI:`XMI_TMG_HOLD_LO]};
                    end
                end
                xmi_pkg::ST_HOLD:
                begin
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h0)
                        state_r <= xmi_pkg::ST_TAIL;
                end
                xmi_pkg::ST_TAIL:
                    state_r <= xmi_pkg::ST_IDLE;
                default:
                    state_r <= xmi_pkg::ST_IDLE;
            endcase
        end
    end

    // setup/strobe/hold each spend count+1 cycles; those three extra
    // cycles plus tail make the fixed overhead of 4 (idle launch not counted)
    // read data capture on the last strobe cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata <= 8'h00;
        else if (onchipPend_r)
            rdata <= xramRdata;
        else if (state_r == xmi_pkg::ST_STROBE && cnt_r == 4'h0 && !write_r)
            rdata <= muxed_r ? adIn : dataIn;
    end

    assign busy = (state_r != xmi_pkg::ST_IDLE);
    assign done = onchipPend_r || (state_r == xmi_pkg::ST_TAIL);

    // pin drive
    always_comb
    begin
        pins = '0;
        if (busy)
        begin
            pins.addrHi = addr_r[15:8];
            pins.addrHiDrive = hiDrive_r;
            pins.addrLo = addr_r[7:0];
            pins.latchStb = (state_r == xmi_pkg::ST_ALEH);
            pins.readStb = (state_r == xmi_pkg::ST_STROBE) && !write_r;
            pins.writeStb = (state_r == xmi_pkg::ST_STROBE) && write_r;
            pins.dataOut = wdata_r;
            // in muxed mode data takes the shared pins after latch
            pins.dataDrive = write_r && (state_r == xmi_pkg::ST_SETUP ||
                state_r == xmi_pkg::ST_STROBE || state_r == xmi_pkg::ST_HOLD);
            if (muxed_r && state_r != xmi_pkg::ST_ALEH)
                pins.addrLo = write_r ? wdata_r : addr_r[7:0];
        end
    end

    // cycle counter for access length checks
    logic [6:0] accLen;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            accLen <= 7'd0;
        else if (state_r == xmi_pkg::ST_IDLE)
            accLen <= 7'd1;
        else
            accLen <= accLen + 7'd1;
    end

    a_nomux_min_len: assert property (
        @(posedge clk) disable iff (!arst_n)
        (state_r == xmi_pkg::ST_TAIL && !muxed_r) |-> accLen >= 7'd4)
        else $error("non-multiplexed access too short");

    a_mux_min_len: assert property (
        @(posedge clk) disable iff (!arst_n)
        (state_r == xmi_pkg::ST_TAIL && muxed_r) |-> accLen >= 7'd6)
        else $error("multiplexed access too short");

    a_onchip_quiet: assert property (
        @(posedge clk) disable iff (!arst_n)
        xramEn |-> !pins.readStb && !pins.writeStb && !pins.latchStb)
        else $error("external strobe during on-chip access");

    a_internal_onchip: assert property (
        @(posedge clk) disable iff (!arst_n)
        (reqValid && !busy && mapMode == 2'b00) |=> xramEn && !busy)
        else $error("internal mode went off-chip");

    a_external_offchip: assert property (
        @(posedge clk) disable iff (!arst_n)
        (reqValid && !busy && mapMode == 2'b11) |=> busy && !xramEn)
        else $error("external mode went on-chip");

    a_ale_first: assert property (
        @(posedge clk) disable iff (!arst_n)
        $rose(busy) && muxed_r |-> pins.latchStb)
        else $error("latch strobe not first in multiplexed access");

    a_nomux_no_ale: assert property (
        @(posedge clk) disable iff (!arst_n)
        (busy && !muxed_r) |-> !pins.latchStb)
        else $error("latch strobe in non-multiplexed mode");

    a_hi_nodrive: assert property (
        @(posedge clk) disable iff (!arst_n)
        ($rose(busy) && mapMode == 2'b11 && !$past(req.wide))
            |-> !pins.addrHiDrive)
        else $error("upper address driven in external 8-bit move");

    a_done_pulse: assert property (
        @(posedge clk) disable iff (!arst_n)
        (state_r == xmi_pkg::ST_TAIL) |=> state_r == xmi_pkg::ST_IDLE)
        else $error("access tail not followed by idle");

    a_access_len: assert property (
        @(posedge clk) disable iff (!arst_n)
        (state_r == xmi_pkg::ST_TAIL) |-> accLen == acc_cycles(tmg_r,
            cfg_r[`XMI_CFG_ALE_HI:`XMI_CFG_ALE_LO], muxed_r))
        else $error("access length differs from programmed sum");

endmodule
`default_nettype wire

// *** verilog/xmi_params.svh ***
/*
 * Constants for the external data-memory interface: config and timing
 * field positions, reset values and fixed access overhead.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef XMI_PARAMS_SVH
`define XMI_PARAMS_SVH

`define XMI_CFG_MUX_BIT 4
`define XMI_CFG_MODE_HI 3
`define XMI_CFG_MODE_LO 2
`define XMI_CFG_ALE_HI 1
`define XMI_CFG_ALE_LO 0
`define XMI_CFG_RESET 8'h03
`define XMI_TMG_SETUP_HI 7
`define XMI_TMG_SETUP_LO 6
`define XMI_TMG_STRB_HI 5
`define XMI_TMG_STRB_LO 2
`define XMI_TMG_HOLD_HI 1
`define XMI_TMG_HOLD_LO 0
`define XMI_TMG_RESET 8'hFF
`define XMI_FIXED_CYCLES 4
`define XMI_XDATA_SPACE_BYTES 512
`define XMI_ALIAS_BYTES 4096

`endif

// *** verilog/xmi_pkg.sv ***
/*
 * Types for the external data-memory interface.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package xmi_pkg;

    typedef enum logic [1:0] {
        MAP_INTERNAL = 2'b00,
        MAP_SPLIT_NOBANK = 2'b01,
        MAP_SPLIT_BANK = 2'b10,
        MAP_EXTERNAL = 2'b11
    } xmi_map_t;

    typedef struct packed {
        logic write;
        logic wide;
        logic usePtrB;
        logic [7:0] wdata;
    } xmi_req_t;

    typedef struct packed {
        logic [7:0] addrHi;
        logic addrHiDrive;
        logic [7:0] addrLo;
        logic [7:0] dataOut;
        logic dataDrive;
        logic readStb;
        logic writeStb;
        logic latchStb;
    } xmi_pins_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_ALEH = 7'b000_0010,
        ST_ALEL = 7'b000_0100,
        ST_SETUP = 7'b000_1000,
        ST_STROBE = 7'b001_0000,
        ST_HOLD = 7'b010_0000,
        ST_TAIL = 7'b100_0000
    } xmi_state_t;

endpackage
`default_nettype wire
